// ==== avdc_map.svh ====
`ifndef AVDC_MAP_SVH
`define AVDC_MAP_SVH

// ----------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------
`define AVDC_IDX_RELEASE 12'h12A
`define AVDC_IDX_B1_UPPER 12'h12C
`define AVDC_IDX_B1_LOWER 12'h12E
`define AVDC_IDX_B2_UPPER 12'h130
`define AVDC_IDX_B2_LOWER 12'h132
`define AVDC_IDX_A1_UPPER 12'h134
`define AVDC_IDX_A1_LOWER 12'h136
`define AVDC_IDX_A2_UPPER 12'h138
`define AVDC_IDX_A2_LOWER 12'h13A

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define AVDC_RATE_MSB 11
`define AVDC_UPPER_MSB 15
`define AVDC_LOWER_MSB 3
`define AVDC_RATE_RESET 12'h050
`define AVDC_UPPER_RESET 16'h0000
`define AVDC_LOWER_RESET 4'h0
`define AVDC_RATE_SHIFT 23
`define AVDC_GAIN_UNITY 24'h800000

// ----------------------------------------
// Timing: clock and sample-rate periods
// ----------------------------------------
`define AVDC_CLK_HZ 10000000
`define AVDC_FS_32K 32000
`define AVDC_FS_44K1 44100
`define AVDC_FS_48K 48000
`define AVDC_FS_96K 96000
`define AVDC_PER_32K (`AVDC_CLK_HZ / `AVDC_FS_32K)
`define AVDC_PER_44K1 (`AVDC_CLK_HZ / `AVDC_FS_44K1)
`define AVDC_PER_48K (`AVDC_CLK_HZ / `AVDC_FS_48K)
`define AVDC_PER_96K (`AVDC_CLK_HZ / `AVDC_FS_96K)

`endif

// ==== avdc_pkg.sv ====
`default_nettype none

package avdc_pkg;
    // Sample rate selection from the clock configuration
    typedef enum logic [1:0] {
        AVDC_FS_SEL_32K,
        AVDC_FS_SEL_44K1,
        AVDC_FS_SEL_48K,
        AVDC_FS_SEL_96K
    } avdc_fs_sel_t;

    // One filter coefficient split in its two staging halves
    typedef struct packed {
        logic [15:0] upper;
        logic [3:0] lower;
    } avdc_coef_t;

    // Captured AHB address phase
    typedef struct packed {
        logic valid;
        logic write;
        logic [11:0] index;
    } avdc_aphase_t;

    // Attenuation load from the attack side
    typedef struct packed {
        logic load;
        logic [23:0] gain;
    } avdc_atten_t;
endpackage

`default_nettype wire

// ==== avdc_sample_tick.sv ====
`include "avdc_map.svh"
`default_nettype none

module avdc_sample_tick
    import avdc_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Rate selection and sample strobe
    input wire avdc_fs_sel_t system_sample_rate,
    output logic sample_tick
);
    logic [8:0] count_reg;
    logic [8:0] count_next;
    logic [8:0] period;

    // Cycles per sample for the selected rate
    always_comb begin
        case (system_sample_rate)
            AVDC_FS_SEL_32K: period = 9'(`AVDC_PER_32K);
            AVDC_FS_SEL_44K1: period = 9'(`AVDC_PER_44K1);
            AVDC_FS_SEL_48K: period = 9'(`AVDC_PER_48K);
            default: period = 9'(`AVDC_PER_96K);
        endcase
    end

    // Divider producing one pulse per sample
    always_comb begin
        sample_tick = 1'b0;
        count_next = count_reg + 9'h001;
        if (count_reg >= period - 9'h001) begin
            count_next = 9'h000;
            sample_tick = 1'b1;
        end
    end

    // Divider state
    always_ff @(posedge mclk) begin
        if (reset) begin
            count_reg <= 9'h000;
        end else begin
            count_reg <= count_next;
        end
    end
endmodule

`default_nettype wire

// ==== avdc_regs.sv ====
// How it works
// - Release rate field is 12 bits, read-write, bits 11:0, resets to 0x50.
// - Rate field is per-sample release fraction of remaining headroom, scaled by 2^23.
// - Release step is applied once per sample at the selected system rate.
// - Each coefficient upper register holds 16 read-write bits, resetting to zero.
// - Each coefficient lower register holds 4 read-write bits; bits 15:4 read zero.
//
// Decided for this implementation: the AHB-Lite register port.
`include "avdc_map.svh"
`default_nettype none

module avdc_regs
    import avdc_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Volume control side
    input wire avdc_fs_sel_t system_sample_rate,
    input wire logic auto_volume_control_en,
    input wire avdc_atten_t atten_in,
    output logic [23:0] release_gain,
    output logic sample_tick,
    // Staged coefficients, index 0..3 = B1, B2, A1, A2
    output avdc_coef_t [3:0] coef_stage,
    output logic [79:0] coef_words
);
    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------

    // Slot of an upper register, 4 when none
    function automatic logic [2:0] upper_slot(input logic [11:0] idx);
        if (idx == `AVDC_IDX_B1_UPPER) begin
            upper_slot = 3'h0;
        end else if (idx == `AVDC_IDX_B2_UPPER) begin
            upper_slot = 3'h1;
        end else if (idx == `AVDC_IDX_A1_UPPER) begin
            upper_slot = 3'h2;
        end else if (idx == `AVDC_IDX_A2_UPPER) begin
            upper_slot = 3'h3;
        end else begin
            upper_slot = 3'h4;
        end
    endfunction

    // Slot of a lower register, 4 when none
    function automatic logic [2:0] lower_slot(input logic [11:0] idx);
        if (idx == `AVDC_IDX_B1_LOWER) begin
            lower_slot = 3'h0;
        end else if (idx == `AVDC_IDX_B2_LOWER) begin
            lower_slot = 3'h1;
        end else if (idx == `AVDC_IDX_A1_LOWER) begin
            lower_slot = 3'h2;
        end else if (idx == `AVDC_IDX_A2_LOWER) begin
            lower_slot = 3'h3;
        end else begin
            lower_slot = 3'h4;
        end
    endfunction

    // ----------------------------------------
    // Bus address phase
    // ----------------------------------------
    avdc_aphase_t aphase_reg;
    avdc_aphase_t aphase_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [11:0] req_index;
    logic req_take;

    // Zero-wait slave, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_reg;
    assign req_index = haddr[13:2];
    assign req_take = hsel && htrans[1] && hready;

    // ----------------------------------------
    // Register storage
    // ----------------------------------------
    logic [`AVDC_RATE_MSB:0] rate_reg;
    logic [`AVDC_RATE_MSB:0] rate_next;
    logic [15:0] upper_reg [4];
    logic [15:0] upper_next [4];
    logic [3:0] lower_reg [4];
    logic [3:0] lower_next [4];
    logic do_write;

    assign do_write = aphase_reg.valid && aphase_reg.write;

    // Release rate write, reserved bits dropped
    always_comb begin
        rate_next = rate_reg;
        if (do_write && aphase_reg.index == `AVDC_IDX_RELEASE) begin
            rate_next = hwdata[`AVDC_RATE_MSB:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            rate_reg <= `AVDC_RATE_RESET;
        end else begin
            rate_reg <= rate_next;
        end
    end

    // Four coefficient staging pairs
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_coef
            always_comb begin
                upper_next[gi] = upper_reg[gi];
                lower_next[gi] = lower_reg[gi];
                if (do_write && upper_slot(aphase_reg.index) == 3'(gi)) begin
                    upper_next[gi] = hwdata[`AVDC_UPPER_MSB:0];
                end
                if (do_write && lower_slot(aphase_reg.index) == 3'(gi)) begin
                    lower_next[gi] = hwdata[`AVDC_LOWER_MSB:0];
                end
            end

            always_ff @(posedge mclk) begin
                if (reset) begin
                    upper_reg[gi] <= `AVDC_UPPER_RESET;
                    lower_reg[gi] <= `AVDC_LOWER_RESET;
                end else begin
                    upper_reg[gi] <= upper_next[gi];
                    lower_reg[gi] <= lower_next[gi];
                end
            end

            // Upper bits above lower bits
            assign coef_stage[gi].upper = upper_reg[gi];
            assign coef_stage[gi].lower = lower_reg[gi];
            assign coef_words[gi*20 +: 20] = {upper_reg[gi], lower_reg[gi]};
        end
    endgenerate

    // ----------------------------------------
    // Bus read path
    // ----------------------------------------
    logic [2:0] rd_upper;
    logic [2:0] rd_lower;

    assign rd_upper = upper_slot(req_index);
    assign rd_lower = lower_slot(req_index);

    // Capture address phase and read data
    always_comb begin
        aphase_next.valid = req_take;
        aphase_next.write = hwrite;
        aphase_next.index = req_index;
        rdata_next = rdata_reg;
        if (req_take && !hwrite) begin
            if (req_index == `AVDC_IDX_RELEASE) begin
                rdata_next = {20'h00000, rate_reg};
            end else if (rd_upper != 3'h4) begin
                rdata_next = {16'h0000, upper_reg[rd_upper[1:0]]};
            end else if (rd_lower != 3'h4) begin
                rdata_next = {28'h0000000, lower_reg[rd_lower[1:0]]};
            end else begin
                rdata_next = 32'h00000000;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            aphase_reg <= '0;
            rdata_reg <= 32'h00000000;
        end else begin
            aphase_reg <= aphase_next;
            rdata_reg <= rdata_next;
        end
    end

    // ----------------------------------------
    // Release of attenuation
    // ----------------------------------------
    avdc_sample_tick u_tick (
        .mclk(mclk),
        .reset(reset),
        .system_sample_rate(system_sample_rate),
        .sample_tick(sample_tick)
    );

    logic [23:0] gain_reg;
    logic [23:0] gain_next;
    logic [23:0] headroom;
    logic [35:0] step_prod;
    logic [23:0] step;

    // Step is rate times remaining headroom over 2^23
    assign headroom = `AVDC_GAIN_UNITY - gain_reg;
    assign step_prod = 36'(headroom) * 36'(rate_reg);
    assign step = 24'(step_prod >> `AVDC_RATE_SHIFT);

    // Disable forces unity, else attack load wins, else one step per sample
    always_comb begin
        gain_next = gain_reg;
        if (!auto_volume_control_en) begin
            gain_next = `AVDC_GAIN_UNITY;
        end else if (atten_in.load) begin
            gain_next = (atten_in.gain > `AVDC_GAIN_UNITY) ? `AVDC_GAIN_UNITY : atten_in.gain;
        end else if (sample_tick) begin
            gain_next = (step == 24'h000000 && headroom != 24'h000000) ?
                gain_reg + 24'h000001 : gain_reg + step;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            gain_reg <= `AVDC_GAIN_UNITY;
        end else begin
            gain_reg <= gain_next;
        end
    end

    assign release_gain = gain_reg;
endmodule

`default_nettype wire

// ==== avdc_regs_props.sv ====
`default_nettype none

module avdc_regs_chk
    import avdc_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Bus
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hrdata,
    // Volume control and staging
    input wire logic auto_volume_control_en,
    input wire avdc_atten_t atten_in,
    input wire logic [23:0] release_gain,
    input wire logic sample_tick,
    input wire avdc_coef_t [3:0] coef_stage,
    input wire logic [79:0] coef_words
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    property p_rsv; hrdata[31:16] == 16'h0000; endproperty
    a_rsv: assert property (p_rsv) else $error("upper read bits set");
    property p_words; coef_words == coef_stage; endproperty
    a_words: assert property (p_words) else $error("coef words differ");
    property p_rdhold; !(hsel && htrans[1] && !hwrite) |=> $stable(hrdata); endproperty
    a_rdhold: assert property (p_rdhold) else $error("read data moved");
    property p_tickgap; sample_tick |=> (!sample_tick) [*8]; endproperty
    a_tickgap: assert property (p_tickgap) else $error("ticks too close");
    property p_gainmax; release_gain <= 24'h800000; endproperty
    a_gainmax: assert property (p_gainmax) else $error("gain above unity");
    property p_gainhold;
        !sample_tick && !atten_in.load && auto_volume_control_en |=> $stable(release_gain);
    endproperty
    a_gainhold: assert property (p_gainhold) else $error("gain moved");
    property p_unity;
        !auto_volume_control_en && !atten_in.load |=> release_gain == 24'h800000;
    endproperty
    a_unity: assert property (p_unity) else $error("gain not unity");
    property p_step;
        sample_tick && auto_volume_control_en && !atten_in.load && release_gain < 24'h800000
            |=> release_gain > $past(release_gain);
    endproperty
    a_step: assert property (p_step) else $error("no release step");
endmodule

bind avdc_regs avdc_regs_chk u_chk (.mclk, .reset, .hsel, .htrans, .hwrite, .hrdata,
    .auto_volume_control_en, .atten_in, .release_gain, .sample_tick, .coef_stage, .coef_words);

`default_nettype wire

// ==== avdc_regs_tb.sv ====
`default_nettype none

module avdc_regs_tb
    import avdc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk, reset, hsel, hwrite, hreadyout, hresp, sample_tick, auto_volume_control_en;
    wire hready;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    avdc_fs_sel_t system_sample_rate;
    avdc_atten_t atten_in;
    logic [23:0] release_gain;
    avdc_coef_t [3:0] coef_stage;
    logic [79:0] coef_words;
    int num_errors = 0;
    int total_checks = 0;
    int n;
    int per[4] = '{312, 226, 208, 104};

    assign hready = hreadyout;

    avdc_regs u_dut (.mclk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hreadyout, .hresp(hresp), .hrdata, .system_sample_rate,
        .auto_volume_control_en, .atten_in, .release_gain, .sample_tick, .coef_stage,
        .coef_words);

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Single AHB transfer, read data kept in rd
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge mclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rd, exp);
        chk({31'h0, hresp}, 32'h0);
    endtask

    // Edges up to the next sample tick
    task automatic wait_tick;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (sample_tick !== 1'b1 && n < 400);
        if (sample_tick !== 1'b1) begin
            num_errors++;
            $display("[FAIL] %0t no sample tick", $time);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Clock, watchdog, tests
    // ----------------------------------------
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    initial begin
        #2000000;
        num_errors++;
        give_verdict;
    end

    initial begin
        reset = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        system_sample_rate = AVDC_FS_SEL_48K;
        auto_volume_control_en = 1'b1;
        atten_in = '0;
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        rd_chk(32'h4A8, 32'h50);
        for (int i = 0; i < 8; i++) rd_chk(32'h4B0 + 32'h8 * i, 32'h0);
        xfer(1'b1, 32'h4A8, 32'hFFFF_FFFF);
        rd_chk(32'h4A8, 32'hFFF);
        for (int i = 0; i < 4; i++) begin
            xfer(1'b1, 32'h4B0 + 32'h10 * i, 32'hFFFF_A5C0 + i);
            xfer(1'b1, 32'h4B8 + 32'h10 * i, 32'hFFFF_FFF8 + i);
            rd_chk(32'h4B0 + 32'h10 * i, 32'hA5C0 + i);
            rd_chk(32'h4B8 + 32'h10 * i, 32'h8 + i);
            chk({12'h0, coef_stage[i]}, 32'hA5C08 + 32'h11 * i);
            chk({12'h0, coef_words[20*i +: 20]}, 32'hA5C08 + 32'h11 * i);
        end
        // Unmapped place ignores writes, reads zero
        xfer(1'b1, 32'h4AC, 32'h1234);
        rd_chk(32'h4AC, 32'h0);
        rd_chk(32'h4A8, 32'hFFF);
        for (int s = 0; s < 4; s++) begin
            system_sample_rate <= avdc_fs_sel_t'(s);
            wait_tick;
            wait_tick;
            chk(n, per[s]);
        end
        // One release step from half scale
        xfer(1'b1, 32'h4A8, 32'h284);
        atten_in <= '{load: 1'b1, gain: 24'h400000};
        @(posedge mclk);
        atten_in <= '0;
        wait_tick;
        @(posedge mclk);
        chk(release_gain, 24'h400000 + ((48'h400000 * 48'h284) >> 23));
        auto_volume_control_en <= 1'b0;
        repeat (2) @(posedge mclk);
        chk(release_gain, 24'h800000);
        // Oversized attack load is clamped to unity
        auto_volume_control_en <= 1'b1;
        atten_in <= '{load: 1'b1, gain: 24'hFFFFFF};
        @(posedge mclk);
        atten_in <= '0;
        @(posedge mclk);
        chk(release_gain, 24'h800000);
        // Reset in mid-run brings back reset values
        reset <= 1'b1;
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        rd_chk(32'h4A8, 32'h50);
        rd_chk(32'h4E0, 32'h0);
        rd_chk(32'h4E8, 32'h0);
        chk({12'h0, coef_stage[3]}, 32'h0);
        give_verdict;
    end
endmodule

`default_nettype wire
